// >>> adc_sample_ctrl.sv
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"
// Behaviour
// - Normal sampling starts automatically after the fourth serial clock edge.
// - Normal sampling lasts 12 or 24 serial clocks, per configuration.
// - Falling start strobe begins sampling the selected channel.
// - Rising start strobe enters hold and starts the conversion.
// - Start strobe ignores serial clock and works with chip select high.
// - Extended sampling lasts as long as the strobe stays low.
// - Chip select fall clears edge counter, enables input if frame sync is high, drives output.
// - Input capture stops at 16 edges or chip select rise.
// - Serial output floats once chip select has risen.
// - Conversion clock is internal oscillator or serial clock.
// - Multiplexer selects an external input or one of three test voltages.
// - Reference is internal 2 V, internal 4 V, or external.
// - Software, pin and automatic power down; selectable conversion speed.
// - Results are held in an eight-entry first-in first-out store.
// - Every conversion result is ten bits wide.
// - Input is MSB first; top four bits are the command; twelve data bits follow.
// - Reads send the 10-bit previous result first, then six don't-care bits.
// - Frame sync fall clears the edge counter and enables input capture.
// - End-of-conversion flag low from sample end to result ready, mode 00.
module adc_sample_ctrl
	import adc_ctrl_pkg::*;
(
	input  wire logic                   i_clk,          // 50 MHz system clock
	input  wire logic                   i_reset_n,      // Async reset, active low
	input  wire logic                   i_cs_n,         // Chip select pin
	input  wire logic                   i_sclk,         // Serial clock pin
	input  wire logic                   i_sdi,          // Serial data in pin
	input  wire logic                   i_frame_sync_input_n, // Frame sync pin
	input  wire logic                   i_conversion_start_strobe_n, // Start strobe pin
	input  wire logic                   i_power_down_pin_n, // Hardware power down pin
	input  wire adc_ctrl_pkg::adc_cfg_t i_config_word,  // Configuration word
	input  wire logic [1:0]             i_conv_mode,    // Conversion mode
	input  wire logic [`RESULT_W-1:0]   i_adc_result,   // Result from the analogue core
	output logic                        o_sdo,          // Serial data out
	output logic                        o_sdo_oe,       // Serial out drive enable
	output logic                        o_flag_n,       // EOC or INT output
	output logic                        o_sample,       // Sample switch closed
	output logic                        o_conv_tick,    // Conversion clock tick
	output logic                        o_powered,      // Analogue circuits powered
	output logic                        o_fast,         // Fast conversion speed
	output adc_ctrl_pkg::ref_sel_t      o_ref_sel,      // Reference choice
	output adc_ctrl_pkg::mux_kind_t     o_mux_kind,     // Multiplexer source kind
	output logic [3:0]                  o_mux_channel,  // External channel
	output logic [3:0]                  o_cmd,          // Decoded command nibble
	output logic [11:0]                 o_cfg_data,     // Configuration data bits
	output logic                        o_cmd_valid     // Command frame complete, pulse
);
	import adc_ctrl_pkg::*;

	typedef struct packed {
		logic                 cs_d;
		logic                 fs_d;
		logic                 sclk_d;
		logic                 cst_d;
		logic                 fs_mode;
		logic                 sdi_en;
		logic [4:0]           edges;
		logic [15:0]          shift_in;
		logic [15:0]          shift_out;
		logic                 sdo;
		logic                 sdo_oe;
		conv_state_t          st;
		logic [4:0]           samp_cnt;
		logic [3:0]           conv_cnt;
		logic [1:0]           osc_div;
		logic                 tick;
		logic                 flag_n;
		logic                 sample;
		logic                 powered;
		logic [3:0]           cmd;
		logic [11:0]          cfg_data;
		logic                 cmd_valid;
	} state_t;

	state_t s_reg;
	state_t s_next;
	logic cs_s, sclk_s, sdi_s, fs_s, cst_s, pd_s;
	logic fifo_empty, fifo_full, fifo_push, fifo_pop;
	logic [`RESULT_W-1:0] fifo_data;

	// All pins cross through two flops before use
	bit_sync #(.INIT(1'b1)) u_cs   (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_async(i_cs_n), .o_sync(cs_s));
	bit_sync #(.INIT(1'b0)) u_sclk (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_async(i_sclk), .o_sync(sclk_s));
	bit_sync #(.INIT(1'b0)) u_sdi  (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_async(i_sdi), .o_sync(sdi_s));
	bit_sync #(.INIT(1'b1)) u_fs   (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_async(i_frame_sync_input_n),
		.o_sync(fs_s));
	bit_sync #(.INIT(1'b1)) u_cst  (.i_clk(i_clk), .i_reset_n(i_reset_n),
		.i_async(i_conversion_start_strobe_n), .o_sync(cst_s));
	bit_sync #(.INIT(1'b1)) u_pd   (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_async(i_power_down_pin_n),
		.o_sync(pd_s));

	result_fifo #(.W(`RESULT_W), .AW(`FIFO_AW)) u_fifo (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_push    (fifo_push),
		.i_data    (i_adc_result),
		.i_pop     (fifo_pop),
		.o_data    (fifo_data),
		.o_empty   (fifo_empty),
		.o_full    (fifo_full)
	);

	// Edge events seen by the system clock
	logic cs_fall, cs_rise, fs_fall, sclk_rise, sclk_fall, cst_fall, cst_rise, shift_edge, conv_src;
	assign cs_fall   = s_reg.cs_d && !cs_s;
	assign cs_rise   = !s_reg.cs_d && cs_s;
	assign fs_fall   = s_reg.fs_d && !fs_s;
	assign sclk_rise = !s_reg.sclk_d && sclk_s;
	assign sclk_fall = s_reg.sclk_d && !sclk_s;
	assign cst_fall  = s_reg.cst_d && !cst_s;
	assign cst_rise  = !s_reg.cst_d && cst_s;
	// DSP framing shifts on the falling edge, SPI on the rising edge
	assign shift_edge = s_reg.fs_mode ? sclk_fall : sclk_rise;
	assign conv_src   = i_config_word.sclk_conv_clk ? sclk_rise : (s_reg.osc_div == `OSC_DIV);
	assign fifo_push  = (s_reg.st == S_CONV) && s_reg.tick && (s_reg.conv_cnt == `CONV_TICKS - 4'h1);
	// Popped only where a frame loads it; frame sync alone loads nothing
	assign fifo_pop   = cs_fall && !fifo_empty;

	always_comb begin
		s_next           = s_reg;
		s_next.cs_d      = cs_s;
		s_next.fs_d      = fs_s;
		s_next.sclk_d    = sclk_s;
		s_next.cst_d     = cst_s;
		s_next.cmd_valid = 1'b0;
		s_next.osc_div   = s_reg.osc_div + 2'h1;
		s_next.tick      = conv_src;
		s_next.powered   = pd_s && !i_config_word.sw_pd;

		// Frame start: SPI on chip select, DSP on frame sync
		if (cs_fall) begin
			s_next.edges     = 5'h00;
			s_next.fs_mode   = !fs_s;
			s_next.sdi_en    = fs_s;
			s_next.sdo_oe    = 1'b1;
			s_next.shift_out = {fifo_empty ? i_adc_result : fifo_data, {`DONT_CARE_BITS{1'b0}}};
			s_next.sdo       = fifo_empty ? i_adc_result[`RESULT_W-1] : fifo_data[`RESULT_W-1];
			if (s_reg.flag_n == 1'b0 && i_config_word.flag_is_int) begin
				s_next.flag_n = 1'b1;
			end
		end else if (fs_fall && !cs_s) begin
			s_next.edges   = 5'h00;
			s_next.sdi_en  = 1'b1;
			s_next.fs_mode = 1'b1;
		end else if (cs_rise) begin
			s_next.sdi_en = 1'b0;
			s_next.sdo_oe = 1'b0;
		end else if (!cs_s && shift_edge && s_reg.edges != `FRAME_EDGES) begin
			s_next.edges = s_reg.edges + 5'h01;
			if (s_reg.sdi_en) begin
				s_next.shift_in = {s_reg.shift_in[14:0], sdi_s};
			end
			s_next.shift_out = {s_reg.shift_out[14:0], 1'b0};
			s_next.sdo       = s_reg.shift_out[14];
			if (s_reg.edges == `FRAME_EDGES - 5'h01) begin
				s_next.sdi_en    = 1'b0;
				s_next.sdo_oe    = 1'b0;
				s_next.cmd       = s_reg.shift_in[14:11];
				s_next.cfg_data  = {s_reg.shift_in[10:0], sdi_s};
				s_next.cmd_valid = 1'b1;
			end
		end

		// Sampling and conversion sequence
		unique case (s_reg.st)
			S_IDLE: begin
				if (cst_fall && s_next.powered) begin
					s_next.st     = S_EXT;
					s_next.sample = 1'b1;
				end else if (!cs_s && shift_edge && s_reg.edges == `SAMPLE_START_EDGE - 5'h01
						&& s_next.powered) begin
					s_next.st       = S_SAMPLE;
					s_next.sample   = 1'b1;
					s_next.samp_cnt = i_config_word.long_sample ? `LONG_SAMPLE_EDGES : `SHORT_SAMPLE_EDGES;
				end
			end
			S_SAMPLE: begin
				if (sclk_rise) begin
					s_next.samp_cnt = s_reg.samp_cnt - 5'h01;
					if (s_reg.samp_cnt == 5'h01) begin
						s_next.st       = S_CONV;
						s_next.sample   = 1'b0;
						s_next.conv_cnt = 4'h0;
						if (!i_config_word.flag_is_int && i_conv_mode == 2'b00) begin
							s_next.flag_n = 1'b0;
						end
					end
				end
			end
			S_EXT: begin
				if (cst_rise) begin
					s_next.st       = S_CONV;
					s_next.sample   = 1'b0;
					s_next.conv_cnt = 4'h0;
					if (!i_config_word.flag_is_int && i_conv_mode == 2'b00) begin
						s_next.flag_n = 1'b0;
					end
				end
			end
			S_CONV: begin
				if (s_reg.tick) begin
					s_next.conv_cnt = s_reg.conv_cnt + 4'h1;
					if (s_reg.conv_cnt == `CONV_TICKS - 4'h1) begin
						s_next.st = S_DONE;
					end
				end
			end
			S_DONE: begin
				s_next.st     = S_IDLE;
				// EOC rises on ready; INT falls on ready
				s_next.flag_n = i_config_word.flag_is_int ? 1'b0 : 1'b1;
				if (i_config_word.flag_is_int) begin
					s_next.sdo_oe = 1'b0;
				end
				if (i_config_word.auto_pd) begin
					s_next.powered = 1'b0;
				end
			end
			default: begin
				s_next.st = S_IDLE;
			end
		endcase
		if (!pd_s) begin
			s_next.st     = S_IDLE;
			s_next.sample = 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s_reg <= '{cs_d: 1'b1, fs_d: 1'b1, cst_d: 1'b1, flag_n: 1'b1, st: S_IDLE, default: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from state flops
	assign o_sdo         = s_reg.sdo;
	assign o_sdo_oe      = s_reg.sdo_oe;
	assign o_flag_n      = s_reg.flag_n;
	assign o_sample      = s_reg.sample;
	assign o_conv_tick   = s_reg.tick;
	assign o_powered     = s_reg.powered;
	assign o_cmd         = s_reg.cmd;
	assign o_cfg_data    = s_reg.cfg_data;
	assign o_cmd_valid   = s_reg.cmd_valid;

	// Analogue selections registered once per cycle
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_fast        <= 1'b0;
			o_ref_sel     <= REF_INT_2V;
			o_mux_kind    <= MUX_EXT;
			o_mux_channel <= 4'h0;
		end else begin
			o_fast        <= i_config_word.fast_speed;
			o_ref_sel     <= i_config_word.ref_sel;
			o_mux_kind    <= i_config_word.mux_kind;
			o_mux_channel <= i_config_word.channel;
		end
	end

	property p_cs_rise_float;
		@(posedge i_clk) disable iff (!i_reset_n) cs_rise |=> !o_sdo_oe;
	endproperty
	a_cs_rise_float: assert property (p_cs_rise_float) else $error("sdo still driven after cs rise");

	property p_cs_fall_drive;
		@(posedge i_clk) disable iff (!i_reset_n) cs_fall |=> o_sdo_oe && s_reg.edges == 5'h00;
	endproperty
	a_cs_fall_drive: assert property (p_cs_fall_drive) else $error("cs fall did not start frame");

	property p_stop_at16;
		@(posedge i_clk) disable iff (!i_reset_n) s_reg.edges == `FRAME_EDGES |-> !s_reg.sdi_en;
	endproperty
	a_stop_at16: assert property (p_stop_at16) else $error("input enabled past 16 edges");

	property p_fs_fall;
		@(posedge i_clk) disable iff (!i_reset_n) (fs_fall && !cs_s && !cs_fall) |=> s_reg.sdi_en;
	endproperty
	a_fs_fall: assert property (p_fs_fall) else $error("frame sync did not enable input");

	property p_strobe_fall;
		@(posedge i_clk) disable iff (!i_reset_n)
			(s_reg.st == S_IDLE && cst_fall && pd_s && !i_config_word.sw_pd) |=> o_sample && s_reg.st == S_EXT;
	endproperty
	a_strobe_fall: assert property (p_strobe_fall) else $error("strobe fall did not start sampling");

	property p_strobe_rise;
		@(posedge i_clk) disable iff (!i_reset_n)
			(s_reg.st == S_EXT && cst_rise && pd_s) |=> !o_sample && s_reg.st == S_CONV;
	endproperty
	a_strobe_rise: assert property (p_strobe_rise) else $error("strobe rise did not hold");

	property p_ext_hold;
		@(posedge i_clk) disable iff (!i_reset_n) (s_reg.st == S_EXT && !cst_s && pd_s) |=> o_sample;
	endproperty
	a_ext_hold: assert property (p_ext_hold) else $error("sampling ended with strobe low");

	property p_conv_len;
		@(posedge i_clk) disable iff (!i_reset_n)
			$rose(s_reg.st == S_CONV) |-> !fifo_push ##1 (s_reg.st == S_CONV || !pd_s);
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion ended at once");

	property p_sample_len;
		@(posedge i_clk) disable iff (!i_reset_n)
			$rose(s_reg.st == S_SAMPLE) |-> (s_reg.samp_cnt == `SHORT_SAMPLE_EDGES
				|| s_reg.samp_cnt == `LONG_SAMPLE_EDGES);
	endproperty
	a_sample_len: assert property (p_sample_len) else $error("bad sample length");
endmodule

// >>> adc_ctrl_defines.svh
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH
`define RESULT_W        10
`define FIFO_DEPTH      8
`define FIFO_AW         3
`define SAMPLE_START_EDGE 4'h4
`define SHORT_SAMPLE_EDGES 5'h0c
`define LONG_SAMPLE_EDGES  5'h18
`define FRAME_EDGES     5'h10
`define CMD_MSB         15
`define CMD_LSB         12
`define DONT_CARE_BITS  6
// Conversion takes this many conversion-clock ticks
`define CONV_TICKS      4'ha
// Internal oscillator divider, 50 MHz down to one tick every 4 cycles
`define OSC_DIV         2'h3
// Flag output mode values
`define FLAG_EOC        1'b0
`define FLAG_INT        1'b1
`endif

// >>> adc_ctrl_pkg.sv
`include "adc_ctrl_defines.svh"
package adc_ctrl_pkg;
	typedef enum logic [1:0] {
		MUX_EXT    = 2'b00,
		MUX_TEST_A = 2'b01,
		MUX_TEST_B = 2'b10,
		MUX_TEST_C = 2'b11
	} mux_kind_t;

	typedef enum logic [1:0] {
		REF_INT_2V = 2'b00,
		REF_INT_4V = 2'b01,
		REF_EXT    = 2'b10,
		REF_EXT2   = 2'b11
	} ref_sel_t;

	typedef struct packed {
		logic       long_sample;   // 24 edges instead of 12
		logic       sclk_conv_clk; // Conversion clock from serial clock
		logic       flag_is_int;   // Flag output mode
		logic       auto_pd;       // Power down after each conversion
		logic       sw_pd;         // Software power down
		logic       fast_speed;    // Faster conversion speed
		ref_sel_t   ref_sel;
		mux_kind_t  mux_kind;
		logic [3:0] channel;
	} adc_cfg_t;

	typedef enum logic [2:0] {
		S_IDLE   = 3'b000,
		S_SAMPLE = 3'b001,
		S_EXT    = 3'b010,
		S_CONV   = 3'b011,
		S_DONE   = 3'b100
	} conv_state_t;
endpackage

// >>> bit_sync.sv
`timescale 1ns/1ps
// Two-flop level synchroniser, resets to a given level
module bit_sync #(
	parameter logic INIT = 1'b1
) (
	input  wire logic i_clk,     // System clock
	input  wire logic i_reset_n, // Async reset, active low
	input  wire logic i_async,   // Level from another domain
	output logic      o_sync     // Synchronised level
);
	logic meta_reg;

	// First flop is read only by the second
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			meta_reg <= INIT;
			o_sync   <= INIT;
		end else begin
			meta_reg <= i_async;
			o_sync   <= meta_reg;
		end
	end
endmodule

// >>> result_fifo.sv
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"
// Result store; a full store drops the newest result
module result_fifo #(
	parameter int W  = `RESULT_W,
	parameter int AW = `FIFO_AW
) (
	input  wire logic         i_clk,     // System clock
	input  wire logic         i_reset_n, // Async reset, active low
	input  wire logic         i_push,    // Write one result
	input  wire logic [W-1:0] i_data,    // Result to write
	input  wire logic         i_pop,     // Drop the oldest result
	output logic      [W-1:0] o_data,    // Oldest result
	output logic              o_empty,   // No results held
	output logic              o_full     // All entries used
);
	logic [W-1:0] mem [2**AW];
	logic [AW:0]  wp_reg;
	logic [AW:0]  rp_reg;
	logic         do_push;
	logic         do_pop;

	assign o_empty = (wp_reg == rp_reg);
	assign o_full  = (wp_reg[AW-1:0] == rp_reg[AW-1:0]) && (wp_reg[AW] != rp_reg[AW]);
	assign do_push = i_push && !o_full;
	assign do_pop  = i_pop && !o_empty;
	assign o_data  = mem[rp_reg[AW-1:0]];

	// Storage carries no reset, pointers do
	always_ff @(posedge i_clk) begin
		if (do_push) begin
			mem[wp_reg[AW-1:0]] <= i_data;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wp_reg <= '0;
			rp_reg <= '0;
		end else begin
			if (do_push) begin
				wp_reg <= wp_reg + 1'b1;
			end
			if (do_pop) begin
				rp_reg <= rp_reg + 1'b1;
			end
		end
	end
endmodule

// >>> adc_host_model.sv
`timescale 1ns/1ps
// Host serial port: chip select, serial clock, data and frame sync
module adc_host_model (
	input  wire logic i_clk,  // System clock
	input  wire logic i_sdo,  // Serial data from the block
	output logic      o_cs_n, // Chip select
	output logic      o_sclk, // Serial clock
	output logic      o_sdi,  // Serial data to the block
	output logic      o_fs_n  // Frame sync
);
	// Idle pins at time zero
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_sdi  = 1'b0;
		o_fs_n = 1'b1;
	end

	// Whole clock cycles; four per half period gives 160 ns
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	// One 16-bit frame MSB first; dsp shifts on falls after frame sync
	task automatic frame(input logic [15:0] w, input logic dsp, output logic [15:0] rd);
		rd = 16'h0;
		tick(1);
		o_fs_n <= ~dsp;
		o_sclk <= dsp; // DSP idles high so each bit is shifted on a fall
		tick(4);
		o_cs_n <= 1'b0;
		tick(8);
		if (dsp) begin
			o_fs_n <= 1'b1;
			tick(8);
			o_fs_n <= 1'b0;
			tick(4);
		end
		for (int i = 15; i >= 0; i--) begin
			o_sdi <= w[i];
			tick(3);
			@(negedge i_clk);
			rd[i] = i_sdo; // Settled well before the shift edge
			tick(1);
			o_sclk <= ~o_sclk;
			tick(4);
			o_sclk <= ~o_sclk;
		end
		tick(4);
		o_cs_n <= 1'b1;
		o_fs_n <= 1'b1;
		o_sdi  <= ~o_sdi; // Released line shows no stale value
		o_sclk <= 1'b0;
		tick(8);
	endtask
endmodule

// >>> adc_sample_ctrl_tb.sv
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"
// Self-checking bench for the sampling and serial control
module adc_sample_ctrl_tb;
	import adc_ctrl_pkg::*;
	logic        clk, reset_n, cs_n, sclk, sdi, fs_n, strobe_n, pwr_n;
	adc_cfg_t    cfg;
	logic [1:0]  mode;
	logic [9:0]  result;
	logic        sdo, sdo_oe, flag_n, sample, conv_tick, powered, fast, cmd_valid;
	ref_sel_t    ref_sel;
	mux_kind_t   mux_kind;
	logic [3:0]  mux_ch, cmd;
	logic [11:0] cfg_data;
	logic [15:0] rd;
	int          mismatches, checks_done, n_valid, n_tick;
	logic        saw_oe, saw_sample, saw_off;

	adc_sample_ctrl adc_sample_ctrl_i (.i_clk(clk), .i_reset_n(reset_n), .i_cs_n(cs_n), .i_sclk(sclk),
		.i_sdi(sdi), .i_frame_sync_input_n(fs_n), .i_conversion_start_strobe_n(strobe_n),
		.i_power_down_pin_n(pwr_n), .i_config_word(cfg), .i_conv_mode(mode), .i_adc_result(result),
		.o_sdo(sdo), .o_sdo_oe(sdo_oe), .o_flag_n(flag_n), .o_sample(sample), .o_conv_tick(conv_tick),
		.o_powered(powered), .o_fast(fast), .o_ref_sel(ref_sel), .o_mux_kind(mux_kind),
		.o_mux_channel(mux_ch), .o_cmd(cmd), .o_cfg_data(cfg_data), .o_cmd_valid(cmd_valid));
	// Undriven output shows the inverse, so a read of a floating line fails
	adc_host_model adc_host_model_i (.i_clk(clk), .i_sdo(sdo_oe ? sdo : ~sdo), .o_cs_n(cs_n), .o_sclk(sclk),
		.o_sdi(sdi), .o_fs_n(fs_n));

	// 50 MHz clock
	initial clk = 1'b0;
	always #10 clk = ~clk;

	// Pulses and levels seen between checks
	always @(posedge clk) begin
		if (cmd_valid === 1'b1) n_valid <= n_valid + 1;
		if (sdo_oe === 1'b1) saw_oe <= 1'b1;
		if (sample === 1'b1) saw_sample <= 1'b1;
		if (conv_tick === 1'b1) n_tick <= n_tick + 1;
		if (powered === 1'b0) saw_off <= 1'b1;
	end

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic close_out;
		if (mismatches == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// One frame after the previous conversion has settled
	task automatic t_frame(input logic [15:0] w, input logic dsp, input logic [9:0] res);
		int nv;
		cyc(60);
		@(negedge clk);
		saw_oe = 1'b0;
		saw_sample = 1'b0;
		nv = n_valid;
		adc_host_model_i.frame(w, dsp, rd);
		@(negedge clk);
		chk("cmd", 16'(w[15:12]), 16'(cmd));
		chk("cfg_data", 16'(w[11:0]), 16'(cfg_data));
		chk("cmd_valid", 16'(nv + 1), 16'(n_valid));
		chk("oe_seen", 16'h1, 16'(saw_oe));
		chk("oe_after", 16'h0, 16'(sdo_oe));
		chk("sample_seen", 16'h1, 16'(saw_sample));
		chk("sdo", {res, 6'h0}, rd);
	endtask

	// Extended sampling with chip select high; strobe low time sets the span
	task automatic t_strobe;
		int n;
		cyc(60);
		result <= 10'h14a;
		strobe_n <= 1'b0;
		cyc(6);
		chk("strb_sample", 16'h1, 16'(sample));
		cyc(20);
		chk("strb_hold_low", 16'h1, 16'(sample));
		strobe_n <= 1'b1;
		cyc(6);
		chk("strb_hold", 16'h0, 16'(sample));
		chk("eoc_low", 16'h0, 16'(flag_n));
		n = 0;
		while (flag_n !== 1'b1 && n < 200) begin
			cyc(1);
			n++;
		end
		chk("eoc_end", 16'h1, 16'(flag_n));
	endtask

	// Two stored results come out oldest first
	task automatic t_fifo;
		t_frame(16'h1000, 1'b0, 10'h2b5);
		chk("short_done", 16'h0, 16'(sample));
		t_frame(16'h2000, 1'b0, 10'h14a);
	endtask

	// Long sampling outlasts the frame; pin power down ends it
	task automatic t_long;
		cyc(1);
		cfg.long_sample <= 1'b1;
		t_frame(16'h4000, 1'b0, 10'h14a);
		chk("long_on", 16'h1, 16'(sample));
		@(posedge clk);
		pwr_n <= 1'b0;
		cyc(5);
		chk("pin_pd", 16'h0, 16'(powered));
		chk("pd_idle", 16'h0, 16'(sample));
		pwr_n <= 1'b1;
		cfg.long_sample <= 1'b0;
		cyc(5);
		chk("pin_up", 16'h1, 16'(powered));
	endtask

	// Interrupt flag and auto power down on a strobe conversion; next frame start clears the flag
	task automatic t_int;
		cfg.flag_is_int <= 1'b1;
		cfg.auto_pd <= 1'b1;
		cyc(4);
		@(negedge clk);
		saw_off = 1'b0;
		@(posedge clk);
		strobe_n <= 1'b0;
		cyc(10);
		chk("int_sample", 16'h1, 16'(sample));
		strobe_n <= 1'b1;
		cyc(80);
		chk("int_flag", 16'h0, 16'(flag_n));
		chk("auto_pd", 16'h1, 16'(saw_off));
		t_frame(16'h5000, 1'b0, 10'h14a);
		chk("int_clear", 16'h1, 16'(flag_n));
	endtask

	// Every mux kind and reference choice, software power down, conversion clock source
	task automatic t_config;
		int nt;
		for (int k = 0; k < 4; k++) begin
			cfg.mux_kind <= mux_kind_t'(k[1:0]);
			cfg.ref_sel <= ref_sel_t'(k[1:0]);
			cfg.channel <= 4'(k * 5);
			cfg.fast_speed <= k[0];
			cyc(3);
			chk("mux_kind", 16'(k), 16'(mux_kind));
			chk("mux_ch", 16'(k * 5), 16'(mux_ch));
			chk("ref_sel", 16'(k), 16'(ref_sel));
			chk("fast", 16'(k % 2), 16'(fast));
		end
		cfg.sw_pd <= 1'b1;
		cyc(3);
		chk("sw_pd", 16'h0, 16'(powered));
		cfg.sw_pd <= 1'b0;
		// Internal oscillator ticks at a fixed rate; an idle serial clock gives none
		nt = n_tick;
		cyc(40);
		chk("osc_ticks", 16'(40 / (`OSC_DIV + 1)), 16'(n_tick - nt));
		cfg.sclk_conv_clk <= 1'b1;
		cyc(2);
		nt = n_tick;
		cyc(40);
		chk("sclk_ticks", 16'h0, 16'(n_tick - nt));
		cfg.sclk_conv_clk <= 1'b0;
	endtask

	// Main sequence
	initial begin
		reset_n = 1'b0;
		strobe_n = 1'b1;
		pwr_n = 1'b1;
		cfg = '0;
		mode = 2'b00;
		result = 10'h2b5;
		mismatches = 0;
		checks_done = 0;
		n_valid = 0;
		n_tick = 0;
		saw_oe = 1'b0;
		saw_sample = 1'b0;
		saw_off = 1'b0;
		cyc(2);
		@(negedge clk);
		chk("rst_oe", 16'h0, 16'(sdo_oe));
		chk("rst_flag", 16'h1, 16'(flag_n));
		chk("rst_sample", 16'h0, 16'(sample));
		@(posedge clk);
		reset_n <= 1'b1;
		cyc(5);
		t_frame(16'ha5c3, 1'b0, 10'h2b5);
		t_strobe;
		t_fifo;
		t_frame(16'h3e01, 1'b1, 10'h14a);
		t_long;
		t_config;
		t_int;
		close_out;
	end

	// Hang guard, far beyond the fewer than two thousand cycles needed
	initial begin
		#400000;
		mismatches++;
		close_out;
	end
endmodule
